// *** testbench/arcc_top_properties.sv ***
`timescale 1ns/1ps
module arcc_props #(parameter CHANNELS = 8) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire converter_clock_o,
  input wire low_power_select_o,
  input wire long_sample_select_o,
  input wire [1:0] mode_o,
  input wire [CHANNELS-1:0] pin_oe_o,
  input wire [CHANNELS-1:0] pin_pullup_o,
  input wire [CHANNELS-1:0] port_read_o,
  input wire irq_o
);
  reg [7:0] cfg_reg;
  reg [7:0] mask_reg;
  reg [CHANNELS-1:0] sel_reg;
  reg [3:0] age_reg;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadows of written registers and an age count since the last config write
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= 8'h00;
      mask_reg <= 8'h00;
      sel_reg <= '0;
      age_reg <= 4'h0;
    end else begin
      if (wr_i && addr_i == 4'h4) cfg_reg <= wdata_i;
      if (wr_i && addr_i == 4'h8) mask_reg <= wdata_i;
      if (wr_i && addr_i == 4'h5) sel_reg <= wdata_i[CHANNELS-1:0];
      if (wr_i && addr_i == 4'h4) age_reg <= 4'h0;
      else if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
    end
  end
  ////////////////////////////////////////
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata not idle");
  pin_oe_a: assert property ((pin_oe_o & sel_reg & $past(sel_reg)) == '0) else $error("pin driven");
  pullup_a: assert property ((pin_pullup_o & sel_reg & $past(sel_reg)) == '0) else $error("pullup on");
  port_rd_a: assert property ((port_read_o & sel_reg & $past(sel_reg)) == '0) else $error("port read");
  cfg_copy_a: assert property ({low_power_select_o, long_sample_select_o, mode_o} ==
    $past({cfg_reg[7], cfg_reg[4:2]})) else $error("config outputs wrong");
  irq_mask_a: assert property ($past(mask_reg) == 8'h00 |-> !irq_o) else $error("masked irq");
  div_one_a: assert property (age_reg > 4'h4 && {cfg_reg[6:5], cfg_reg[1:0]} == 4'h0 |->
    converter_clock_o != $past(converter_clock_o)) else $error("div1 clock");
  div_two_a: assert property (age_reg > 4'h8 && {cfg_reg[6:5], cfg_reg[1:0]} == 4'h4 |->
    converter_clock_o != $past(converter_clock_o, 2)) else $error("div2 clock");
  cover property (rd_i && addr_i == 4'h0);
  cover property (irq_o);
  cover property (sel_reg != '0 && $past(sel_reg) != '0);
endmodule
bind arcc_top arcc_props #(.CHANNELS(CHANNELS)) prop_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .converter_clock_o(converter_clock_o), .low_power_select_o(low_power_select_o),
  .long_sample_select_o(long_sample_select_o), .mode_o(mode_o), .pin_oe_o(pin_oe_o),
  .pin_pullup_o(pin_pullup_o), .port_read_o(port_read_o), .irq_o(irq_o));

// *** testbench/tb_arcc_top.sv ***
`timescale 1ns/1ps
module tb_arcc_top;
  reg core_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, conv_done_i = 1'b0;
  reg alternate_clock_i = 1'b0, internal_async_clock_i = 1'b0, c;
  reg [3:0] addr_i = 4'h0;
  reg [7:0] wdata_i = 8'h00, d;
  reg [9:0] conv_result_i = 10'h000;
  reg [7:0] port_out_i = 8'hff, port_oe_i = 8'hff, port_pullup_i = 8'hff, pin_in_i = 8'hff;
  wire [7:0] rdata_o, pin_out_o, pin_oe_o, pin_pullup_o, port_read_o;
  wire converter_clock_o, low_power_select_o, long_sample_select_o, irq_o;
  wire [1:0] mode_o;
  integer err_count = 0, tests_run = 0, i, k, e;
  reg [63:0] rows [0:7];
  arcc_top #(.CHANNELS(8)) dut_u (.*);
  initial forever #25 core_clk_i = ~core_clk_i;
  always #200 alternate_clock_i = ~alternate_clock_i;
  always #250 internal_async_clock_i = ~internal_async_clock_i;
  ////////////////////////////////////////
  task wr(input [3:0] a, input [7:0] v);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task conv(input [9:0] r);
    @(posedge core_clk_i);
    conv_done_i <= 1'b1;
    conv_result_i <= r;
    @(posedge core_clk_i);
    conv_done_i <= 1'b0;
  endtask
  task chk(input [47:0] name, input [7:0] exp, input [7:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("FAIL %0s exp %h got %h", name, exp, got);
    end
  endtask
  task rchk(input [3:0] a, input [7:0] exp);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk("rdata", exp, rdata_o);
  endtask
  task settle;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task give_verdict;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1000000;
    err_count = err_count + 1;
    give_verdict;
  end
  ////////////////////////////////////////
  initial begin
    // Config, ctrl, cmp high, cmp low, result, high, low
    rows[0] = 64'h08_00_00_00_03a5_03_a5; // ten bits
    rows[1] = 64'h08_01_02_00_01ff_01_ff; // less than
    rows[2] = 64'h08_01_01_00_02ff_01_ff; // kept
    rows[3] = 64'h08_03_03_10_030f_01_ff; // below bound
    rows[4] = 64'h08_03_03_10_0310_03_10; // equal
    rows[5] = 64'h00_03_03_40_0150_00_50; // eight bits
    rows[6] = 64'h00_01_00_40_0045_00_50; // kept
    rows[7] = 64'h00_00_00_00_02c7_00_c7; // eight bits
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rchk(4'h4, 8'h00);
    rchk(4'hf, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      wr(4'h4, rows[i][63:56]);
      wr(4'h6, rows[i][55:48]);
      wr(4'h2, rows[i][47:40]);
      wr(4'h3, rows[i][39:32]);
      conv(rows[i][25:16]);
      rchk(4'h0, rows[i][15:8]); // high
      rchk(4'h1, rows[i][7:0]); // low
    end
    wr(4'h4, 8'h08);
    wr(4'h6, 8'h00);
    rchk(4'h6, 8'h04); // invalid set
    conv(10'h155);
    rchk(4'h6, 8'h00); // invalid cleared
    rchk(4'h0, 8'h01);
    conv(10'h2aa);
    rchk(4'h1, 8'h55); // dropped
    conv(10'h2aa);
    rchk(4'h0, 8'h02); // released
    rchk(4'h1, 8'haa);
    wr(4'h4, 8'h00);
    conv(10'h033);
    rchk(4'h0, 8'h00);
    conv(10'h044);
    rchk(4'h1, 8'h44); // no lock
    wr(4'h4, 8'hd8);
    rchk(4'h4, 8'hd8); // readback
    chk("cfgout", 8'h0e, {4'h0, low_power_select_o, long_sample_select_o, mode_o});
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h4, (i == 0) ? 8'h20 : i[7:0]);
      repeat (20) @(posedge core_clk_i);
      c = converter_clock_o;
      k = 0;
      e = (i == 0) ? 40 : (i == 1) ? 40 : (i == 2) ? 10 : 8;
      repeat (80) begin
        @(negedge core_clk_i);
        k = k + (converter_clock_o !== c);
        c = converter_clock_o;
      end
      chk("ckrate", 8'h01, {7'h0, k >= e - 1 && k <= e + 1}); // divide and source
    end
    wr(4'h5, 8'h0f);
    settle;
    chk("pinoe", 8'hf0, pin_oe_o); // high impedance
    chk("pullup", 8'hf0, pin_pullup_o); // pullup off
    chk("portrd", 8'hf0, port_read_o); // reads zero
    chk("pinout", 8'hf0, pin_out_o); // per channel
    wr(4'h4, 8'h00);
    wr(4'h7, 8'h07);
    wr(4'h8, 8'h01);
    conv(10'h011);
    settle;
    chk("irq", 8'h01, {7'h0, irq_o});
    wr(4'h8, 8'h00);
    settle;
    chk("irqmsk", 8'h00, {7'h0, irq_o});
    wr(4'h7, 8'h01);
    wr(4'h8, 8'h01);
    settle;
    chk("irqclr", 8'h00, {7'h0, irq_o});
    give_verdict;
  end
endmodule

// *** verilog/arcc_regs.vh ***
`ifndef ARCC_REGS_VH
`define ARCC_REGS_VH

// Register offsets
`define ARCC_OFS_RESULT_HIGH 4'h0
`define ARCC_OFS_RESULT_LOW 4'h1
`define ARCC_OFS_CMP_HIGH 4'h2
`define ARCC_OFS_CMP_LOW 4'h3
`define ARCC_OFS_CONFIG 4'h4
`define ARCC_OFS_PIN_LOW 4'h5
`define ARCC_OFS_CMP_CTRL 4'h6
`define ARCC_OFS_IRQ_STATUS 4'h7
`define ARCC_OFS_IRQ_MASK 4'h8

// Configuration fields
`define ARCC_CFG_LOW_POWER 7
`define ARCC_CFG_DIV_HI 6
`define ARCC_CFG_DIV_LO 5
`define ARCC_CFG_LONG_SAMPLE 4
`define ARCC_CFG_MODE_HI 3
`define ARCC_CFG_MODE_LO 2
`define ARCC_CFG_CLK_HI 1
`define ARCC_CFG_CLK_LO 0

// Mode codes
`define ARCC_MODE_8BIT 2'h0
`define ARCC_MODE_10BIT 2'h2

// Compare control fields
`define ARCC_CC_ENABLE 0
`define ARCC_CC_GE 1

// Interrupt status fields
`define ARCC_IRQ_STORED 0
`define ARCC_IRQ_DISCARD 1
`define ARCC_IRQ_INVALID 2

// Reset values
`define ARCC_RST_CONFIG 8'h00
`define ARCC_RST_BYTE 8'h00

`endif

// *** verilog/arcc_top.v ***
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "arcc_regs.vh"

module arcc_top #(
  parameter CHANNELS = 8
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire conv_done_i,
  input wire [9:0] conv_result_i,
  input wire alternate_clock_i,
  input wire internal_async_clock_i,
  output reg converter_clock_o,
  output reg low_power_select_o,
  output reg long_sample_select_o,
  output reg [1:0] mode_o,
  input wire [CHANNELS-1:0] port_out_i,
  input wire [CHANNELS-1:0] port_oe_i,
  input wire [CHANNELS-1:0] port_pullup_i,
  input wire [CHANNELS-1:0] pin_in_i,
  output reg [CHANNELS-1:0] pin_out_o,
  output reg [CHANNELS-1:0] pin_oe_o,
  output reg [CHANNELS-1:0] pin_pullup_o,
  output reg [CHANNELS-1:0] port_read_o,
  output reg irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [9:0] result_reg;
  reg [7:0] cmp_high_reg;
  reg [7:0] cmp_low_reg;
  reg [7:0] config_reg;
  reg [7:0] pin_low_reg;
  reg [1:0] cmp_ctrl_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;
  reg lock_reg;
  reg invalid_reg;
  reg alt_s1_reg, alt_s2_reg, async_s1_reg, async_s2_reg;
  reg [CHANNELS-1:0] pin_s1_reg, pin_s2_reg;
  reg half_reg;
  reg [2:0] div_cnt_reg;

  // Address match for one register offset
  function sel_hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      sel_hit = (addr == ofs);
    end
  endfunction

  wire rd_hi = rd_i && sel_hit(addr_i, `ARCC_OFS_RESULT_HIGH);
  wire rd_lo = rd_i && sel_hit(addr_i, `ARCC_OFS_RESULT_LOW);
  wire [1:0] mode = config_reg[`ARCC_CFG_MODE_HI:`ARCC_CFG_MODE_LO];
  wire ten_bit = mode == `ARCC_MODE_10BIT;

  ////////////////////////////////////////////////////////////////////////
  // Compare
  // compare value width
  wire [9:0] cmp_val = ten_bit ? {cmp_high_reg[1:0], cmp_low_reg} : {2'h0, cmp_low_reg};
  wire [9:0] new_res = ten_bit ? conv_result_i : {2'h0, conv_result_i[7:0]};
  wire cmp_true = cmp_ctrl_reg[`ARCC_CC_GE] ? (new_res >= cmp_val) : (new_res < cmp_val);
  wire cmp_ok = !cmp_ctrl_reg[`ARCC_CC_ENABLE] || cmp_true;
  wire blocked = lock_reg && ten_bit;
  wire store = conv_done_i && cmp_ok && !blocked;
  wire discard = conv_done_i && cmp_ok && blocked;
  wire cfg_wr = wr_i && sel_hit(addr_i, `ARCC_OFS_CONFIG);
  wire mode_chg = cfg_wr && wdata_i[`ARCC_CFG_MODE_HI:`ARCC_CFG_MODE_LO] != mode;

  ////////////////////////////////////////////////////////////////////////
  // Result path
  // result load
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_reg <= 10'h000;
    end else if (store) begin
      result_reg <= new_res;
    end
  end

  // interlock
  // Low read or eight-bit mode releases the lock
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_reg <= 1'b0;
    end else if (rd_lo || !ten_bit) begin
      lock_reg <= 1'b0;
    end else if (rd_hi) begin
      lock_reg <= 1'b1;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      invalid_reg <= 1'b0;
    end else if (mode_chg) begin
      invalid_reg <= 1'b1;
    end else if (store) begin
      invalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  wire [2:0] irq_events = {mode_chg, discard, store};
  wire cmp_high_wr = wr_i && sel_hit(addr_i, `ARCC_OFS_CMP_HIGH);
  wire cmp_low_wr = wr_i && sel_hit(addr_i, `ARCC_OFS_CMP_LOW);
  wire pin_low_wr = wr_i && sel_hit(addr_i, `ARCC_OFS_PIN_LOW);
  wire cmp_ctrl_wr = wr_i && sel_hit(addr_i, `ARCC_OFS_CMP_CTRL);
  wire irq_mask_wr = wr_i && sel_hit(addr_i, `ARCC_OFS_IRQ_MASK);
  wire irq_status_wr = wr_i && sel_hit(addr_i, `ARCC_OFS_IRQ_STATUS);

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_high_reg <= `ARCC_RST_BYTE;
    end else if (cmp_high_wr) begin
      cmp_high_reg <= {6'h00, wdata_i[1:0]};
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_low_reg <= `ARCC_RST_BYTE;
    end else if (cmp_low_wr) begin
      cmp_low_reg <= wdata_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      config_reg <= `ARCC_RST_CONFIG;
    end else if (cfg_wr) begin
      config_reg <= wdata_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_low_reg <= `ARCC_RST_BYTE;
    end else if (pin_low_wr) begin
      pin_low_reg <= wdata_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_ctrl_reg <= 2'h0;
    end else if (cmp_ctrl_wr) begin
      cmp_ctrl_reg <= wdata_i[1:0];
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_reg <= 3'h0;
    end else if (irq_mask_wr) begin
      irq_mask_reg <= wdata_i[2:0];
    end
  end

  // Set wins over write-one-to-clear
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_reg <= 3'h0;
    end else if (irq_status_wr) begin
      irq_status_reg <= (irq_status_reg & ~wdata_i[2:0]) | irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port
  reg [7:0] rdata_next;
  always @* begin
    rdata_next = 8'h00;
    case (addr_i)
      // upper bits zero at eight bits
      `ARCC_OFS_RESULT_HIGH: rdata_next = {6'h00, ten_bit ? result_reg[9:8] : 2'h0};
      `ARCC_OFS_RESULT_LOW: rdata_next = result_reg[7:0];
      `ARCC_OFS_CMP_HIGH: rdata_next = cmp_high_reg;
      `ARCC_OFS_CMP_LOW: rdata_next = cmp_low_reg;
      `ARCC_OFS_CONFIG: rdata_next = config_reg;
      `ARCC_OFS_PIN_LOW: rdata_next = pin_low_reg;
      `ARCC_OFS_CMP_CTRL: rdata_next = {5'h00, invalid_reg, cmp_ctrl_reg};
      `ARCC_OFS_IRQ_STATUS: rdata_next = {5'h00, irq_status_reg};
      `ARCC_OFS_IRQ_MASK: rdata_next = {5'h00, irq_mask_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // Data stand in the cycle after each cycle of rd_i, then idle at zero
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? rdata_next : 8'h00;
    end
  end

  // Same-cycle events included, so the line rises one cycle after the event
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_status_reg | irq_events) & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter clock
  // Two-stage synchroniser for the alternate source
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alt_s1_reg <= 1'b0;
      alt_s2_reg <= 1'b0;
    end else begin
      alt_s1_reg <= alternate_clock_i;
      alt_s2_reg <= alt_s1_reg;
    end
  end

  // Two-stage synchroniser for the internal source
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      async_s1_reg <= 1'b0;
      async_s2_reg <= 1'b0;
    end else begin
      async_s1_reg <= internal_async_clock_i;
      async_s2_reg <= async_s1_reg;
    end
  end

  // Bus clock halved
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end

  reg src_tick;
  reg src_prev_reg;
  always @* begin
    src_tick = 1'b0;
    case (config_reg[`ARCC_CFG_CLK_HI:`ARCC_CFG_CLK_LO])
      2'h0: src_tick = 1'b1;
      2'h1: src_tick = half_reg;
      2'h2: src_tick = alt_s2_reg && !src_prev_reg;
      default: src_tick = async_s2_reg && !src_prev_reg;
    endcase
  end

  wire src_level = config_reg[`ARCC_CFG_CLK_LO] ? async_s2_reg : alt_s2_reg;
  wire [2:0] div_last = (3'h1 << config_reg[`ARCC_CFG_DIV_HI:`ARCC_CFG_DIV_LO]) - 3'h1;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_prev_reg <= 1'b0;
      div_cnt_reg <= 3'h0;
      converter_clock_o <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
      if (src_tick) begin
        if (div_cnt_reg >= div_last) begin
          div_cnt_reg <= 3'h0;
          converter_clock_o <= ~converter_clock_o;
        end else begin
          div_cnt_reg <= div_cnt_reg + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter settings and pins
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_power_select_o <= 1'b0;
      long_sample_select_o <= 1'b0;
      mode_o <= `ARCC_MODE_8BIT;
    end else begin
      low_power_select_o <= config_reg[`ARCC_CFG_LOW_POWER];
      long_sample_select_o <= config_reg[`ARCC_CFG_LONG_SAMPLE];
      mode_o <= mode;
    end
  end

  // One pin slice per channel
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : pin_gen
      always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_s1_reg[ch] <= 1'b0;
          pin_s2_reg[ch] <= 1'b0;
        end else begin
          pin_s1_reg[ch] <= pin_in_i[ch];
          pin_s2_reg[ch] <= pin_s1_reg[ch];
        end
      end

      always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_out_o[ch] <= 1'b0;
          pin_oe_o[ch] <= 1'b0;
          pin_pullup_o[ch] <= 1'b0;
          port_read_o[ch] <= 1'b0;
        end else begin
          pin_out_o[ch] <= port_out_i[ch] & ~pin_low_reg[ch];
          pin_oe_o[ch] <= port_oe_i[ch] & ~pin_low_reg[ch];
          pin_pullup_o[ch] <= port_pullup_i[ch] & ~pin_low_reg[ch];
          port_read_o[ch] <= pin_s2_reg[ch] & ~pin_low_reg[ch];
        end
      end
    end
  endgenerate

endmodule
